// ===== rtl/bit_exec_pkg.sv
package bit_exec_pkg;
  // ==========================================================================
  // instruction word layout
  localparam int unsigned INSN_W      = 14;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned BIDX_W      = 3;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_LSB    = 0;
  localparam int unsigned BIDX_LSB    = 7;
  localparam int unsigned OPC_LSB     = 10;
  localparam int unsigned OPC_W       = 4;
  // ==========================================================================
  // opcodes in bits 13:10
  localparam logic [3:0] OPC_SET_BIT  = 4'h5;  // 01 01
  localparam logic [3:0] OPC_SKIP_CLR = 4'h6;  // 01 10
  localparam logic [3:0] OPC_SKIP_SET = 4'h7;  // 01 11
  // ==========================================================================
  // execution states
  typedef enum logic [0:0] {
    ST_EXEC = 1'b0,
    ST_NOP  = 1'b1
  } exec_state_e;
endpackage : bit_exec_pkg

// ===== rtl/bit_mask_gen.sv
`timescale 1ns/1ns
// one-hot bit mask generator, registered-free decode helper
module bit_mask_gen #(
  parameter int unsigned BIDX_W = 3
) (
  // bit index in
  input  wire logic [BIDX_W-1:0]      bit_idx,
  // one-hot mask out
  output logic      [(1<<BIDX_W)-1:0] mask
);
  // ==========================================================================
  // decode
  always_comb begin
    mask          = '0;
    mask[bit_idx] = 1'b1;
  end
endmodule : bit_mask_gen

// ===== rtl/bit_test_skip_set_exec.sv
`timescale 1ns/1ns
// ==========================================================================
// Functional notes
// - bit-clear test decodes 0110, skips on zero
// - clear-test skip flushes fetch, two cycles
// - bit set decodes 0101, writes one
// - bit-set test decodes 0111, skips on one
// - set-test skip flushes fetch, two cycles
// - address bits 6:0, bit index 9:7
module bit_test_skip_set_exec #(
  parameter int unsigned DATA_W = bit_exec_pkg::DATA_W
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              srst,
  // instruction from fetch stage
  input  wire logic                              insn_valid,
  input  wire logic [bit_exec_pkg::INSN_W-1:0]   insn,
  // register file access
  output logic      [bit_exec_pkg::ADDR_W-1:0]   file_addr,
  output logic      [bit_exec_pkg::BIDX_W-1:0]   bit_idx,
  input  wire logic [DATA_W-1:0]                 file_rdata,
  output logic                                   file_we,
  output logic      [DATA_W-1:0]                 file_wdata,
  // pipeline control
  output logic                                   flush_nop,
  output logic                                   busy
);
  // ==========================================================================
  // elaboration check
  // the one-hot mask covers exactly one data word, so the widths must agree
  if (DATA_W != (1 << bit_exec_pkg::BIDX_W)) begin : g_bad_width
    $error("data width must match the bit index range");
  end

  // ==========================================================================
  // field decode
  // opcode field of a fetched word
  function automatic logic [bit_exec_pkg::OPC_W-1:0] opc_of(
    input logic [bit_exec_pkg::INSN_W-1:0] w
  );
    return w[bit_exec_pkg::OPC_LSB +: bit_exec_pkg::OPC_W];
  endfunction : opc_of

  // one opcode hit, only in an execute slot with a word that fetch vouches for
  function automatic logic slot_hit(
    input logic                            slot_ok,
    input logic [bit_exec_pkg::OPC_W-1:0]  code,
    input logic [bit_exec_pkg::OPC_W-1:0]  want
  );
    return slot_ok && (code == want);
  endfunction : slot_hit

  // value of the addressed bit, picked through the one-hot mask
  function automatic logic masked_bit(
    input logic [DATA_W-1:0] data,
    input logic [DATA_W-1:0] sel
  );
    return |(data & sel);
  endfunction : masked_bit

  // decode results, sequencer state and write-back state
  logic [bit_exec_pkg::OPC_W-1:0]   opc;
  logic [DATA_W-1:0]                mask;
  logic                             slot_open;
  logic                             addr_bit;
  bit_exec_pkg::exec_state_e        state_r;
  bit_exec_pkg::exec_state_e        state_nxt;
  logic                             is_set;
  logic                             is_sclr;
  logic                             is_sset;
  logic                             take_skip;
  logic                             file_we_r;
  logic                             file_we_nxt;
  logic [DATA_W-1:0]                file_wdata_r;
  logic [DATA_W-1:0]                file_wdata_nxt;

  // operand fields straight from the word; the register file reads combinationally
  assign opc       = opc_of(insn);
  assign file_addr = insn[bit_exec_pkg::ADDR_LSB +: bit_exec_pkg::ADDR_W];
  assign bit_idx   = insn[bit_exec_pkg::BIDX_LSB +: bit_exec_pkg::BIDX_W];

  // one-hot mask of the addressed bit
  bit_mask_gen #(
    .BIDX_W (bit_exec_pkg::BIDX_W)
  ) bit_mask_gen_inst (
    .bit_idx (bit_idx),
    .mask    (mask)
  );

  // the substituted nop slot ignores the fetched word, which fetch has dropped
  assign slot_open = insn_valid && (state_r == bit_exec_pkg::ST_EXEC);

  // ==========================================================================
  // opcode qualification
  always_comb begin
    is_set    = slot_hit(slot_open, opc, bit_exec_pkg::OPC_SET_BIT);
    is_sclr   = slot_hit(slot_open, opc, bit_exec_pkg::OPC_SKIP_CLR);
    is_sset   = slot_hit(slot_open, opc, bit_exec_pkg::OPC_SKIP_SET);
    addr_bit  = masked_bit(file_rdata, mask);
    // the skip reads the live bit; no status flag is touched on either path
    take_skip = (is_sclr && !addr_bit)
             || (is_sset && addr_bit);
  end

  // ==========================================================================
  // sequencer: a skip costs one extra nop cycle
  // a test word that lands in the nop slot is never qualified, so two skips
  // are at least two cycles apart, with the nop slot between them
  always_comb begin
    state_nxt = bit_exec_pkg::ST_EXEC;
    unique case (state_r)
      bit_exec_pkg::ST_EXEC: begin
        if (take_skip) begin
          state_nxt = bit_exec_pkg::ST_NOP;
        end
      end
      bit_exec_pkg::ST_NOP: begin
        state_nxt = bit_exec_pkg::ST_EXEC;
      end
    endcase
  end

  // flush is combinational so fetch drops its word in the same cycle; the
  // price is a path from the read data through the mask to the fetch stage
  assign flush_nop = take_skip;
  assign busy      = (state_r == bit_exec_pkg::ST_NOP);

  // ==========================================================================
  // write-back: read-modify-write, other bits keep their read value
  // the write lands one cycle late, so the register file must hold the set
  // word's address itself; a set straight after a set to the same register
  // reads the old value and loses the first bit unless the file forwards
  always_comb begin
    file_we_nxt    = is_set;
    file_wdata_nxt = file_rdata | mask;
  end

  // sequencer state; reset wins over a skip decided in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= bit_exec_pkg::ST_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // write strobe and data
  always_ff @(posedge clk) begin
    if (srst) begin
      file_we_r    <= 1'b0;
      file_wdata_r <= '0;
    end else begin
      file_we_r    <= file_we_nxt;
      file_wdata_r <= file_wdata_nxt;
    end
  end

  // data outputs straight from the flip-flops
  assign file_we    = file_we_r;
  assign file_wdata = file_wdata_r;

  // ==========================================================================
  // checks: skip timing
  // a skip costs exactly one substituted slot, a kept test costs none;
  // reset must leave no slot pending
  chk_skip_clear_nop: assert property (@(posedge clk) disable iff (srst)
    is_sclr && !file_rdata[bit_idx] |-> flush_nop ##1 busy ##1 !busy)
    else $error("clear-test skip did not take two cycles");
  chk_noskip_clear: assert property (@(posedge clk) disable iff (srst)
    is_sclr && file_rdata[bit_idx] |-> !flush_nop ##1 !busy)
    else $error("clear-test skipped on a set bit");
  chk_skip_set_nop: assert property (@(posedge clk) disable iff (srst)
    is_sset && file_rdata[bit_idx] |-> flush_nop ##1 busy ##1 !busy)
    else $error("set-test skip did not take two cycles");
  chk_noskip_set: assert property (@(posedge clk) disable iff (srst)
    is_sset && !file_rdata[bit_idx] |-> !flush_nop ##1 !busy)
    else $error("set-test skipped on a clear bit");
  chk_busy_one_slot: assert property (@(posedge clk) disable iff (srst)
    busy |=> !busy)
    else $error("nop slot lasted more than one cycle");
  chk_nop_no_flush: assert property (@(posedge clk) disable iff (srst)
    busy |-> !flush_nop && !file_we_nxt)
    else $error("nop slot executed the discarded word");
  chk_reset_idle: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> !busy && !file_we)
    else $error("outputs not idle after reset");

  // ==========================================================================
  // checks: write-back
  // the write data are judged against the read value one cycle back, so a
  // wrong mask or a lost bit shows up whenever the read value had a zero in an affected bit
  chk_set_writes_one: assert property (@(posedge clk) disable iff (srst)
    is_set |=> file_we && file_wdata[$past(bit_idx)])
    else $error("bit set did not write a one");
  chk_set_keeps_rest: assert property (@(posedge clk) disable iff (srst)
    is_set |=> ((file_wdata ^ $past(file_rdata)) & ~$past(mask)) == '0)
    else $error("bit set disturbed other bits");
  chk_no_write_skip: assert property (@(posedge clk) disable iff (srst)
    (is_sclr || is_sset) |=> !file_we)
    else $error("bit test wrote the register file");
  chk_we_after_set: assert property (@(posedge clk) disable iff (srst)
    file_we |-> $past(is_set))
    else $error("write strobe without a bit set before it");

  // ==========================================================================
  // checks: decode
  // the three fields must tile the word with no gap and no overlap, and a
  // word that fetch does not vouch for must do nothing
  chk_field_split: assert property (@(posedge clk) disable iff (srst)
    {opc, bit_idx, file_addr} == insn)
    else $error("operand fields taken from wrong bits");
  chk_invalid_idle: assert property (@(posedge clk) disable iff (srst)
    !insn_valid |-> !flush_nop ##1 !file_we)
    else $error("unvouched word was executed");

  // ==========================================================================
  // covers for the main scenarios
  cov_skip_clear:   cover property (@(posedge clk) is_sclr && flush_nop);
  cov_skip_set:     cover property (@(posedge clk) is_sset && flush_nop);
  cov_set_bit:      cover property (@(posedge clk) is_set);
  cov_back2back:    cover property (@(posedge clk) flush_nop ##2 flush_nop);
  cov_invalid_word: cover property (@(posedge clk) !insn_valid && opc == bit_exec_pkg::OPC_SKIP_CLR);
endmodule : bit_test_skip_set_exec

// ===== tb/bit_test_skip_set_exec_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module bit_test_skip_set_exec_bench;
  // ==========================================================================
  // stimulus and design
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        insn_valid = 1'b0;
  logic [13:0] insn = 14'h0000;
  logic [7:0]  file_rdata = 8'h00;
  logic [6:0]  file_addr;
  logic [2:0]  bit_idx;
  logic        file_we, flush_nop, busy;
  logic [7:0]  file_wdata;
  int          miscompares = 0;
  int          total_checks = 0;
  always #5 clk = ~clk;
  bit_test_skip_set_exec bit_test_skip_set_exec_inst (.clk(clk), .srst(srst),
    .insn_valid(insn_valid), .insn(insn), .file_addr(file_addr), .bit_idx(bit_idx),
    .file_rdata(file_rdata), .file_we(file_we), .file_wdata(file_wdata),
    .flush_nop(flush_nop), .busy(busy));
  // ==========================================================================
  // shared helpers; inputs change on the falling edge, looked at 1 ns later
  task automatic drive(input logic [13:0] w, input logic [7:0] rd);
    @(negedge clk);
    insn = w;
    insn_valid = 1'b1;
    file_rdata = rd;
    #1;
  endtask : drive
  task automatic give_verdict;
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // set every bit index, highest address at the top index; the strobe of
  // the previous set must have dropped after one cycle
  task automatic set_bits;
    logic [6:0] f;
    for (int b = 0; b < 8; b++) begin
      f = (b == 7) ? 7'h7f : 7'(b * 17);
      drive({4'h5, 3'(b), f}, 8'h5a);
      `CHK(file_we, 1'b0)
      `CHK(file_addr, f)
      `CHK(bit_idx, 3'(b))
      `CHK(flush_nop, 1'b0)
      drive(14'h0000, 8'h00);
      `CHK(file_we, 1'b1)
      `CHK(file_wdata, 8'h5a | (8'h01 << b))
    end
  endtask : set_bits
  // ==========================================================================
  // test each bit both ways; other bits hold the opposite value so a wrong
  // index is caught. the word after a skip is a set, which must not write
  task automatic test_skips(input logic [3:0] opc);
    logic [7:0] rd;
    logic       sk;
    for (int b = 0; b < 8; b++) begin
      for (int v = 0; v < 2; v++) begin
        rd = v ? (8'h01 << b) : ~(8'h01 << b);
        sk = (opc == 4'h6) ? (v == 0) : (v == 1);
        drive({opc, 3'(b), 7'(b + 120)}, rd);
        `CHK(flush_nop, sk)
        drive({4'h5, 3'h2, 7'h11}, 8'h00);
        `CHK(busy, sk)
        `CHK(flush_nop, 1'b0)
        drive(14'h0000, 8'h00);
        `CHK(busy, 1'b0)
        `CHK(file_we, !sk)
        if (!sk) `CHK(file_wdata, 8'h04)
      end
    end
  endtask : test_skips
  // ==========================================================================
  // other patterns, 0100 from the same group and 1000 from outside it, must do nothing here
  task automatic foreign_words;
    drive(14'h1285, 8'h00);
    `CHK(flush_nop, 1'b0)
    drive(14'h2285, 8'hff);
    `CHK(file_we, 1'b0)
    `CHK(flush_nop, 1'b0)
    drive(14'h0000, 8'h00);
    `CHK(file_we, 1'b0)
    `CHK(busy, 1'b0)
  endtask : foreign_words
  // ==========================================================================
  // skip, skip again straight after the slot, then sets back to back; a test
  // word in the nop slot would skip if it were wrongly executed
  task automatic back_to_back;
    drive({4'h6, 3'h3, 7'h05}, 8'h00);
    `CHK(flush_nop, 1'b1)
    drive({4'h7, 3'h3, 7'h05}, 8'hff);
    `CHK(busy, 1'b1)
    `CHK(flush_nop, 1'b0)
    drive({4'h7, 3'h3, 7'h05}, 8'h08);
    `CHK(busy, 1'b0)
    `CHK(flush_nop, 1'b1)
    drive({4'h5, 3'h0, 7'h01}, 8'h00);
    `CHK(busy, 1'b1)
    drive({4'h5, 3'h1, 7'h02}, 8'h80);
    `CHK(file_we, 1'b0)
    drive({4'h5, 3'h2, 7'h03}, 8'h01);
    `CHK(file_we, 1'b1)
    `CHK(file_wdata, 8'h82)
    @(negedge clk);
    insn_valid = 1'b0;
    insn = {4'h6, 3'h4, 7'h06};
    file_rdata = 8'h00;
    #1;
    `CHK(file_we, 1'b1)
    `CHK(file_wdata, 8'h05)
    `CHK(flush_nop, 1'b0)
    @(negedge clk);
    insn = {4'h5, 3'h4, 7'h06};
    #1;
    `CHK(busy, 1'b0)
    `CHK(file_we, 1'b0)
    drive(14'h0000, 8'h00);
    `CHK(file_we, 1'b0)
  endtask : back_to_back
  // ==========================================================================
  // reset lands in the cycle that decides a skip; it must win over the skip
  // while the write pending from the set still shows, and the first word after release must execute
  task automatic reset_in_slot;
    drive({4'h5, 3'h4, 7'h07}, 8'h00);
    @(negedge clk);
    srst = 1'b1;
    insn = {4'h6, 3'h4, 7'h07};
    file_rdata = 8'h00;
    #1;
    `CHK(file_we, 1'b1)
    `CHK(flush_nop, 1'b1)
    @(negedge clk);
    srst = 1'b0;
    insn = {4'h5, 3'h0, 7'h07};
    file_rdata = 8'h40;
    #1;
    `CHK(busy, 1'b0)
    `CHK(file_we, 1'b0)
    drive(14'h0000, 8'h00);
    `CHK(file_we, 1'b1)
    `CHK(file_wdata, 8'h41)
  endtask : reset_in_slot
  // ==========================================================================
  // main sequence and watchdog; the run is about 140 cycles
  initial begin
    repeat (10) @(posedge clk);
    #1;
    `CHK(file_we, 1'b0)
    `CHK(busy, 1'b0)
    @(negedge clk);
    srst = 1'b0;
    set_bits();
    test_skips(4'h6);
    test_skips(4'h7);
    foreign_words();
    back_to_back();
    reset_in_slot();
    give_verdict();
  end
  initial begin
    #20000;
    miscompares++;
    give_verdict();
  end
endmodule : bit_test_skip_set_exec_bench
